// >>> core/ickb_cfg.svh
`ifndef ICKB_CFG_SVH
`define ICKB_CFG_SVH

`define ICKB_KEY7_W 376
`define ICKB_KEY5_W 377
`define ICKB_K7_FRAG 180
`define ICKB_K7_NONFIRST 181
`define ICKB_K7_OPTS 182
`define ICKB_K7_DSCP 183
`define ICKB_K7_DIP_UP 189
`define ICKB_K7_DIP_LO 205
`define ICKB_K7_SIP_UP 269
`define ICKB_K7_SIP_LO 285
`define ICKB_K7_TCPUDP 349
`define ICKB_K7_TCP 350
`define ICKB_K7_SPORT 351
`define ICKB_K7_RNG 367
`define ICKB_K5_DSCP 65
`define ICKB_K5_DIP 71
`define ICKB_K5_SIP 199
`define ICKB_K5_NXT 327
`define ICKB_K5_TCPUDP 335
`define ICKB_K5_TCP 336
`define ICKB_K5_RNG 337
`define ICKB_K5_PAY 345
`define ICKB_IHL_BASE 4'h5
`define ICKB_REG_BOUND 8'h00
`define ICKB_REG_TYPE 8'h20
`define ICKB_REG_CTRL 8'h40
`define ICKB_REG_STAT 8'h44
`define ICKB_CTRL_RST 1'h1
`endif

// >>> core/ickb_pkg.sv
package ickb_pkg;
    typedef enum logic [2:0] {
        ICKB_FK_ETYPE = 3'b000,
        ICKB_FK_LLC   = 3'b001,
        ICKB_FK_SNAP  = 3'b010,
        ICKB_FK_IPV4  = 3'b011,
        ICKB_FK_IPV6  = 3'b100,
        ICKB_FK_OAM   = 3'b101,
        ICKB_FK_ARP   = 3'b110
    } ickb_kind_t;
    typedef enum logic [2:0] {
        ICKB_RT_SPORT  = 3'b000,
        ICKB_RT_DPORT  = 3'b001,
        ICKB_RT_EITHER = 3'b010,
        ICKB_RT_VID    = 3'b011,
        ICKB_RT_DSCP   = 3'b100,
        ICKB_RT_OFF    = 3'b111
    } ickb_rng_t;
endpackage

// >>> core/ickb_range_bank.sv
`timescale 1ns/1ps
module ickb_range_bank (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic core_ce,
    input wire logic cfg_wr,
    input wire logic cfg_type_sel,
    input wire logic [2:0] cfg_idx,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic l4_ok,
    input wire logic [15:0] sport,
    input wire logic [15:0] dport,
    input wire logic [11:0] vid,
    input wire logic [5:0] dscp,
    output logic [7:0] mask
);
    logic [15:0] lo_q [8];
    logic [15:0] hi_q [8];
    ickb_pkg::ickb_rng_t type_q [8];
    logic [15:0] lo_d [8];
    logic [15:0] hi_d [8];
    ickb_pkg::ickb_rng_t type_d [8];

    always_comb begin
        cfg_rdata = cfg_type_sel ? {29'h0, type_q[cfg_idx]}
                                 : {hi_q[cfg_idx], lo_q[cfg_idx]};
    end

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_rng
            logic in_s;
            logic in_d;
            logic in_v;
            logic in_q;
            always_comb begin
                lo_d[g] = lo_q[g];
                hi_d[g] = hi_q[g];
                type_d[g] = type_q[g];
                if (cfg_wr && cfg_idx == 3'(g)) begin
                    if (cfg_type_sel) begin
                        type_d[g] = ickb_pkg::ickb_rng_t'(cfg_wdata[2:0]);
                    end else begin
                        lo_d[g] = cfg_wdata[15:0];
                        hi_d[g] = cfg_wdata[31:16];
                    end
                end
            end
            always_ff @(posedge core_clk) begin
                if (!rst_n) begin
                    lo_q[g] <= 16'h0;
                    hi_q[g] <= 16'h0;
                    type_q[g] <= ickb_pkg::ICKB_RT_OFF;
                end else if (core_ce) begin
                    lo_q[g] <= lo_d[g];
                    hi_q[g] <= hi_d[g];
                    type_q[g] <= type_d[g];
                end
            end
            // ports only count for TCP_OR_UDP_FLAG frames, bounds are inclusive
            always_comb begin
                in_s = l4_ok && sport >= lo_q[g] && sport <= hi_q[g];
                in_d = l4_ok && dport >= lo_q[g] && dport <= hi_q[g];
                in_v = {4'h0, vid} >= lo_q[g] && {4'h0, vid} <= hi_q[g];
                in_q = {10'h0, dscp} >= lo_q[g] && {10'h0, dscp} <= hi_q[g];
                case (type_q[g])
                    ickb_pkg::ICKB_RT_SPORT: mask[g] = in_s;
                    ickb_pkg::ICKB_RT_DPORT: mask[g] = in_d;
                    ickb_pkg::ICKB_RT_EITHER: mask[g] = in_s | in_d;
                    ickb_pkg::ICKB_RT_VID: mask[g] = in_v;
                    ickb_pkg::ICKB_RT_DSCP: mask[g] = in_q;
                    default: mask[g] = 1'b0;
                endcase
            end
        end
    endgenerate
endmodule // ickb_range_bank

// >>> core/ickb_key_builder.sv
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "ickb_cfg.svh"
module ickb_key_builder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic core_ce,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic hdr_valid,
    input wire logic [2:0] frame_kind,
    input wire logic is_tcp,
    input wire logic is_udp,
    input wire logic ip4_more_frag,
    input wire logic [12:0] ip4_frag_ofs,
    input wire logic [3:0] ip4_hdr_len,
    input wire logic [5:0] cls_dscp,
    input wire logic [127:0] ip_dip,
    input wire logic [127:0] ip_sip,
    input wire logic [7:0] ip6_next_hdr,
    input wire logic [31:0] l4_head,
    input wire logic [127:0] frame_payload,
    input wire logic [7:0] llc_ctrl,
    input wire logic [39:0] snap_pid,
    input wire logic vlan_tagged,
    input wire logic [11:0] frame_vid,
    input wire logic [11:0] port_vid,
    output logic key_valid,
    output logic [`ICKB_KEY7_W-1:0] seven_tuple_key,
    output logic [`ICKB_KEY5_W-1:0] ipv6_five_tuple_key
);
    logic [`ICKB_KEY7_W-1:0] k7_d;
    logic [`ICKB_KEY5_W-1:0] k5_d;
    logic valid_d;
    logic [31:0] rdata_d;
    logic en_q;
    logic en_d;
    logic [7:0] last_mask_q;
    logic [7:0] last_mask_d;
    logic [15:0] key_cnt_q;
    logic [15:0] key_cnt_d;
    logic take;
    logic is_ip4;
    logic is_ip6;
    logic l4_ok;
    logic [15:0] sport;
    logic [15:0] dport;
    logic [7:0] rng_mask;
    logic [31:0] bank_rdata;
    logic bank_wr;
    logic bank_sel_rd;
    logic [2:0] bank_idx;
    ickb_pkg::ickb_kind_t kind;

    always_comb begin
        kind = ickb_pkg::ickb_kind_t'(frame_kind);
        is_ip4 = kind == ickb_pkg::ICKB_FK_IPV4;
        is_ip6 = kind == ickb_pkg::ICKB_FK_IPV6;
        l4_ok = (is_ip4 || is_ip6) && (is_tcp || is_udp);
        sport = l4_ok ? l4_head[31:16] : 16'h0;
        dport = l4_ok ? l4_head[15:0] : 16'h0;
        take = hdr_valid && en_q;
    end

    // register window: bounds and types for the range bank, then ctrl/stat
    always_comb begin
        bank_wr = reg_wr && reg_addr[7:6] == 2'h0 && reg_addr[1:0] == 2'h0;
        bank_sel_rd = reg_addr[5];
        bank_idx = reg_addr[4:2];
    end

    ickb_range_bank u_rng (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .core_ce(core_ce),
        .cfg_wr(bank_wr),
        .cfg_type_sel(bank_sel_rd),
        .cfg_idx(bank_idx),
        .cfg_wdata(reg_wdata),
        .cfg_rdata(bank_rdata),
        .l4_ok(l4_ok),
        .sport(sport),
        .dport(dport),
        .vid(vlan_tagged ? frame_vid : port_vid),
        .dscp(cls_dscp),
        .mask(rng_mask)
    );

    always_comb begin
        en_d = en_q;
        if (reg_wr && reg_addr == `ICKB_REG_CTRL) begin
            en_d = reg_wdata[0];
        end
        rdata_d = 32'h0;
        if (reg_rd) begin
            if (reg_addr[7:6] == 2'h0 && reg_addr[1:0] == 2'h0) begin
                rdata_d = bank_rdata;
            end else if (reg_addr == `ICKB_REG_CTRL) begin
                rdata_d = {31'h0, en_q};
            end else if (reg_addr == `ICKB_REG_STAT) begin
                rdata_d = {key_cnt_q, 8'h0, last_mask_q};
            end
        end
        last_mask_d = take ? rng_mask : last_mask_q;
        key_cnt_d = take ? key_cnt_q + 16'h1 : key_cnt_q;
    end

    // key assembly: everything not listed here stays zero
    always_comb begin
        k7_d = '0;
        k5_d = '0;
        valid_d = take;
        k7_d[`ICKB_K7_FRAG] = is_ip4 &&
            (ip4_more_frag || ip4_frag_ofs != 13'h0);
        k7_d[`ICKB_K7_NONFIRST] = is_ip4 && ip4_frag_ofs != 13'h0;
        // options are flagged only; l4 fields still read at the fixed spot
        k7_d[`ICKB_K7_OPTS] = is_ip4 &&
            ip4_hdr_len > `ICKB_IHL_BASE;
        k7_d[`ICKB_K7_DSCP +: 6] = cls_dscp;
        unique case (kind)
            ickb_pkg::ICKB_FK_LLC: begin
                k7_d[`ICKB_K7_DIP_LO +: 64] = frame_payload[71:8];
                k7_d[`ICKB_K7_SIP_LO +: 64] =
                    {llc_ctrl, frame_payload[127:72]};
            end
            ickb_pkg::ICKB_FK_SNAP: begin
                k7_d[`ICKB_K7_DIP_LO +: 64] = frame_payload[87:24];
                k7_d[`ICKB_K7_SIP_LO +: 64] =
                    {snap_pid[23:0], frame_payload[127:88]};
            end
            ickb_pkg::ICKB_FK_IPV4: begin
                k7_d[`ICKB_K7_DIP_LO +: 64] = {32'h0, ip_dip[31:0]};
                k7_d[`ICKB_K7_SIP_LO +: 64] = {32'h0, ip_sip[31:0]};
            end
            ickb_pkg::ICKB_FK_IPV6: begin
                k7_d[`ICKB_K7_DIP_UP +: 16] = ip_dip[127:112];
                k7_d[`ICKB_K7_SIP_UP +: 16] = ip_sip[127:112];
                k7_d[`ICKB_K7_DIP_LO +: 64] = ip_dip[63:0];
                k7_d[`ICKB_K7_SIP_LO +: 64] = ip_sip[63:0];
            end
            ickb_pkg::ICKB_FK_ETYPE, ickb_pkg::ICKB_FK_OAM,
            ickb_pkg::ICKB_FK_ARP: begin
                k7_d[`ICKB_K7_DIP_LO +: 64] = frame_payload[63:0];
                k7_d[`ICKB_K7_SIP_LO +: 64] = frame_payload[127:64];
            end
            default: begin
                k7_d[`ICKB_K7_DIP_LO +: 64] = 64'h0;
            end
        endcase
        k7_d[`ICKB_K7_TCPUDP] = l4_ok;
        k7_d[`ICKB_K7_TCP] = l4_ok && is_tcp;
        k7_d[`ICKB_K7_SPORT +: 16] = sport;
        k7_d[`ICKB_K7_RNG +: 8] = rng_mask;
        if (is_ip6) begin
            k5_d[`ICKB_K5_DSCP +: 6] = cls_dscp;
            k5_d[`ICKB_K5_DIP +: 128] = ip_dip;
            k5_d[`ICKB_K5_SIP +: 128] = ip_sip;
            k5_d[`ICKB_K5_NXT +: 8] = ip6_next_hdr;
            k5_d[`ICKB_K5_TCPUDP] = l4_ok;
            k5_d[`ICKB_K5_TCP] = l4_ok && is_tcp;
            k5_d[`ICKB_K5_RNG +: 8] = rng_mask;
            k5_d[`ICKB_K5_PAY +: 32] = l4_ok ? l4_head : 32'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_valid <= 1'b0;
            seven_tuple_key <= '0;
            ipv6_five_tuple_key <= '0;
            reg_rdata <= 32'h0;
            en_q <= `ICKB_CTRL_RST;
            last_mask_q <= 8'h0;
            key_cnt_q <= 16'h0;
        end else if (core_ce) begin
            key_valid <= valid_d;
            if (take) begin
                seven_tuple_key <= k7_d;
                ipv6_five_tuple_key <= k5_d;
            end
            reg_rdata <= rdata_d;
            en_q <= en_d;
            last_mask_q <= last_mask_d;
            key_cnt_q <= key_cnt_d;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic acc;
    assign acc = core_ce && take;

    property p_nonfirst;
        acc && is_ip4 && ip4_frag_ofs != 13'h0
            |=> seven_tuple_key[`ICKB_K7_NONFIRST];
    endproperty
    a_nonfirst: assert property (p_nonfirst)
        else $error("nonfirst fragment flag missing");

    property p_first_frag;
        acc && is_ip4 && ip4_frag_ofs == 13'h0 && ip4_more_frag
            |=> seven_tuple_key[`ICKB_K7_FRAG]
                && !seven_tuple_key[`ICKB_K7_NONFIRST];
    endproperty
    a_first_frag: assert property (p_first_frag)
        else $error("first fragment flags wrong");

    property p_opts;
        acc |=> seven_tuple_key[`ICKB_K7_OPTS] ==
            ($past(is_ip4) && $past(ip4_hdr_len) > 4'h5);
    endproperty
    a_opts: assert property (p_opts)
        else $error("options flag wrong");

    property p_dscp;
        acc && is_ip6 |=> seven_tuple_key[`ICKB_K7_DSCP +: 6] ==
            $past(cls_dscp) && ipv6_five_tuple_key[`ICKB_K5_DSCP +: 6] ==
            $past(cls_dscp);
    endproperty
    a_dscp: assert property (p_dscp)
        else $error("dscp not placed");

    property p_ip6_addr;
        acc && is_ip6 |=> seven_tuple_key[`ICKB_K7_DIP_UP +: 16] ==
            $past(ip_dip[127:112]) &&
            seven_tuple_key[`ICKB_K7_SIP_UP +: 16] == $past(ip_sip[127:112])
            && ipv6_five_tuple_key[`ICKB_K5_SIP +: 128] == $past(ip_sip);
    endproperty
    a_ip6_addr: assert property (p_ip6_addr)
        else $error("ipv6 address fields wrong");

    property p_llc;
        acc && kind == ickb_pkg::ICKB_FK_LLC
            |=> seven_tuple_key[`ICKB_K7_SIP_LO + 56 +: 8] == $past(llc_ctrl);
    endproperty
    a_llc: assert property (p_llc)
        else $error("llc control byte misplaced");

    property p_ip4_dip;
        acc && is_ip4 |=> seven_tuple_key[`ICKB_K7_DIP_LO +: 64] ==
            {32'h0, $past(ip_dip[31:0])};
    endproperty
    a_ip4_dip: assert property (p_ip4_dip)
        else $error("ipv4 destination misplaced");

    property p_no_l4;
        acc && !(is_tcp || is_udp) |=> seven_tuple_key[`ICKB_K7_SPORT +: 16]
            == 16'h0 && !seven_tuple_key[`ICKB_K7_TCPUDP];
    endproperty
    a_no_l4: assert property (p_no_l4)
        else $error("l4 fields not cleared");

    property p_tcp6;
        acc && is_ip6 && is_tcp |=> ipv6_five_tuple_key[`ICKB_K5_TCP] &&
            ipv6_five_tuple_key[`ICKB_K5_PAY +: 32] == $past(l4_head) &&
            seven_tuple_key[`ICKB_K7_TCP];
    endproperty
    a_tcp6: assert property (p_tcp6)
        else $error("ipv6 tcp key wrong");

    property p_rng;
        acc |=> seven_tuple_key[`ICKB_K7_RNG +: 8] == last_mask_q &&
            ipv6_five_tuple_key[`ICKB_K5_RNG +: 8] ==
            ($past(is_ip6) ? last_mask_q : 8'h0);
    endproperty
    a_rng: assert property (p_rng)
        else $error("range mask not in key");

    property p_valid;
        core_ce |=> key_valid == $past(take);
    endproperty
    a_valid: assert property (p_valid)
        else $error("key valid timing wrong");

    property p_snap;
        acc && kind == ickb_pkg::ICKB_FK_SNAP
            |=> seven_tuple_key[`ICKB_K7_DIP_LO +: 64] ==
                $past(frame_payload[87:24]) &&
            seven_tuple_key[`ICKB_K7_SIP_LO + 40 +: 24] ==
                $past(snap_pid[23:0]);
    endproperty
    a_snap: assert property (p_snap)
        else $error("snap payload fields misplaced");

    property p_l4_flags;
        acc |=> seven_tuple_key[`ICKB_K7_TCPUDP] ==
            ($past(is_ip4 || is_ip6) && $past(is_tcp || is_udp)) &&
            seven_tuple_key[`ICKB_K7_SPORT +: 16] ==
            ($past(l4_ok) ? $past(l4_head[31:16]) : 16'h0);
    endproperty
    a_l4_flags: assert property (p_l4_flags)
        else $error("layer-4 flags or source port wrong");

    property p_ip6_five;
        acc && is_ip6 |=> ipv6_five_tuple_key[`ICKB_K5_DIP +: 128] ==
            $past(ip_dip) &&
            ipv6_five_tuple_key[`ICKB_K5_NXT +: 8] == $past(ip6_next_hdr);
    endproperty
    a_ip6_five: assert property (p_ip6_five)
        else $error("five-tuple address or next header wrong");

    property p_udp6;
        acc && is_ip6 && is_udp && !is_tcp
            |=> ipv6_five_tuple_key[`ICKB_K5_PAY +: 32] == $past(l4_head) &&
            ipv6_five_tuple_key[`ICKB_K5_TCPUDP] &&
            !ipv6_five_tuple_key[`ICKB_K5_TCP];
    endproperty
    a_udp6: assert property (p_udp6)
        else $error("ipv6 udp payload or flags wrong");

    // keys hold between accepted headers so a lookup may be repeated
    property p_hold;
        !acc |=> $stable(seven_tuple_key) && $stable(ipv6_five_tuple_key);
    endproperty
    a_hold: assert property (p_hold)
        else $error("keys changed without a header");

    c_ip6_tcp: cover property (acc && is_ip6 && is_tcp);
    c_ip4_frag: cover property (acc && is_ip4 && ip4_frag_ofs != 13'h0);
    c_rng_hit: cover property (acc && rng_mask != 8'h0);
    c_refused: cover property (hdr_valid && core_ce && !en_q);
endmodule // ickb_key_builder

// >>> dv/ickb_cam_model.sv
`timescale 1ns/1ps
`include "ickb_cfg.svh"
module ickb_cam_model (
    input wire logic key_valid,
    input wire logic [`ICKB_KEY7_W-1:0] seven_tuple_key,
    output logic hit
);
    // one entry: unfragmented tcp frames; the options flag and every
    // field that does not apply stay don't-care
    logic [`ICKB_KEY7_W-1:0] care;
    logic [`ICKB_KEY7_W-1:0] val;
    always_comb begin
        care = '0;
        val = '0;
        care[`ICKB_K7_FRAG] = 1'b1;
        care[`ICKB_K7_TCPUDP] = 1'b1;
        care[`ICKB_K7_TCP] = 1'b1;
        val[`ICKB_K7_TCPUDP] = 1'b1;
        val[`ICKB_K7_TCP] = 1'b1;
        hit = key_valid && (((seven_tuple_key ^ val) & care) == '0);
    end
endmodule // ickb_cam_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk, rst_n, core_ce, reg_wr, reg_rd, hdr_valid, hit;
    logic is_tcp, is_udp, ip4_more_frag, vlan_tagged, key_valid, en;
    logic [7:0] reg_addr, ip6_next_hdr, llc_ctrl, last_m;
    logic [31:0] reg_wdata, reg_rdata, l4_head, seed, rd_q;
    logic [2:0] frame_kind;
    logic [12:0] ip4_frag_ofs;
    logic [3:0] ip4_hdr_len;
    logic [5:0] cls_dscp;
    logic [127:0] ip_dip, ip_sip, frame_payload;
    logic [39:0] snap_pid;
    logic [11:0] frame_vid, port_vid;
    logic [375:0] seven_tuple_key;
    logic [376:0] ipv6_five_tuple_key;
    logic [15:0] lo[8], hi[8], cnt;
    logic [2:0] ty[8];
    logic [375:0] q7[$];
    logic [376:0] q5[$];
    logic [31:0] qr[$];
    logic qh[$];
    logic rd_pend, ce_q, kv_q;
    int fail_count, samples_checked;

    ickb_key_builder ickb_key_builder_inst (.*);
    ickb_cam_model ickb_cam_model_inst (.key_valid(key_valid),
        .seven_tuple_key(seven_tuple_key), .hit(hit));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(string n, logic [376:0] e, logic [376:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    function automatic logic l4ok();
        return (frame_kind == ickb_pkg::ICKB_FK_IPV4 ||
                frame_kind == ickb_pkg::ICKB_FK_IPV6) && (is_tcp || is_udp);
    endfunction

    function automatic logic [7:0] rng_mask();
        logic [7:0] m;
        logic [15:0] v[5];
        v[0] = l4_head[31:16];
        v[1] = l4_head[15:0];
        v[3] = {4'h0, vlan_tagged ? frame_vid : port_vid};
        v[4] = {10'h000, cls_dscp};
        for (int i = 0; i < 8; i++) begin
            case (ty[i])
                3'h0, 3'h1: m[i] = l4ok() && v[ty[i]] >= lo[i] && v[ty[i]] <= hi[i];
                3'h2: m[i] = l4ok() && ((v[0] >= lo[i] && v[0] <= hi[i]) ||
                                        (v[1] >= lo[i] && v[1] <= hi[i]));
                3'h3, 3'h4: m[i] = v[ty[i]] >= lo[i] && v[ty[i]] <= hi[i];
                default: m[i] = 1'b0;
            endcase
        end
        return m;
    endfunction

    task automatic push_key();
        logic [375:0] k;
        logic [376:0] f;
        logic l;
        k = '0;
        f = '0;
        l = l4ok();
        last_m = rng_mask();
        if (frame_kind == ickb_pkg::ICKB_FK_IPV4) begin
            k[180] = ip4_more_frag || ip4_frag_ofs != 13'h0;
            k[181] = ip4_frag_ofs != 13'h0;
            k[182] = ip4_hdr_len > 4'h5;
            k[268:205] = {32'h0, ip_dip[31:0]};
            k[348:285] = {32'h0, ip_sip[31:0]};
        end else if (frame_kind == ickb_pkg::ICKB_FK_IPV6) begin
            k[204:189] = ip_dip[127:112];
            k[284:269] = ip_sip[127:112];
            k[268:205] = ip_dip[63:0];
            k[348:285] = ip_sip[63:0];
            f[70:65] = cls_dscp;
            f[326:71] = {ip_sip, ip_dip};
            f[334:327] = ip6_next_hdr;
            f[336:335] = {l && is_tcp, l};
            f[344:337] = last_m;
            f[376:345] = l ? l4_head : 32'h0;
        end else if (frame_kind == ickb_pkg::ICKB_FK_LLC) begin
            k[268:205] = frame_payload[71:8];
            k[348:285] = {llc_ctrl, frame_payload[127:72]};
        end else if (frame_kind == ickb_pkg::ICKB_FK_SNAP) begin
            k[268:205] = frame_payload[87:24];
            k[348:285] = {snap_pid[23:0], frame_payload[127:88]};
        end else begin
            k[268:205] = frame_payload[63:0];
            k[348:285] = frame_payload[127:64];
        end
        k[188:183] = cls_dscp;
        k[350:349] = {l && is_tcp, l};
        k[366:351] = l ? l4_head[31:16] : 16'h0000;
        k[374:367] = last_m;
        cnt++;
        q7.push_back(k);
        q5.push_back(f);
        qh.push_back(l && is_tcp && !k[180]);
    endtask

    task automatic idle();
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        hdr_valid <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        {reg_wr, reg_rd, hdr_valid, reg_addr, reg_wdata} <= {3'h4, a, d};
        if (a < 8'h20 && a[1:0] == 2'h0) {hi[a[4:2]], lo[a[4:2]]} = d;
        else if (a < 8'h40 && a[1:0] == 2'h0) ty[a[4:2]] = d[2:0];
        else if (a == 8'h40) en = d[0];
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge core_clk);
        {reg_wr, reg_rd, hdr_valid, reg_addr} <= {3'h2, a};
        qr.push_back(e);
    endtask

    task automatic hdr();
        logic [31:0] t;
        t = xs();
        @(posedge core_clk);
        {reg_wr, reg_rd, hdr_valid} <= 3'h1;
        frame_kind <= 3'(xs() % 7);
        {is_tcp, is_udp, ip4_more_frag, vlan_tagged} <= {t[0], t[1] & ~t[0], t[3:2]};
        ip4_frag_ofs <= t[4] ? 13'h0 : 13'(xs());
        ip4_hdr_len <= 4'(5 + t[8:5] % 11);
        cls_dscp <= 6'(xs());
        l4_head <= {16'(xs() % 64), 16'(xs() % 64)};
        {frame_vid, port_vid} <= {12'(xs() % 64), 12'(xs() % 64)};
        ip_dip <= {xs(), xs(), xs(), xs()};
        ip_sip <= {xs(), xs(), xs(), xs()};
        frame_payload <= {xs(), xs(), xs(), xs()};
        {ip6_next_hdr, llc_ctrl, snap_pid} <= {t[31:16], xs(), t[15:8]};
        #1;
        if (en && core_ce) push_key();
    endtask

    // results are judged mid-cycle so edge updates have settled; after an
    // edge with core_ce low the outputs must simply hold
    always @(negedge core_clk) begin
        if (rst_n && !ce_q) begin
            chk("frozen_reg_rdata", rd_q, reg_rdata);
            chk("frozen_key_valid", kv_q, key_valid);
        end else if (rst_n) begin
            chk("reg_rdata", rd_pend ? qr.pop_front() : 32'h0, reg_rdata);
            if (key_valid === 1'b1 && q7.size() == 0) chk("key_valid", 0, 1);
            else if (key_valid === 1'b1) begin
                chk("seven_tuple_key", q7.pop_front(), seven_tuple_key);
                chk("ipv6_five_tuple_key", q5.pop_front(), ipv6_five_tuple_key);
                chk("lookup_hit", qh.pop_front(), hit);
            end
        end
        rd_pend = reg_rd && core_ce;
        {ce_q, kv_q, rd_q} = {core_ce, key_valid, reg_rdata};
    end

    initial begin
        #100us;
        fail_count++;
        final_report();
    end

    initial begin
        seed = 32'h5e517bbb;
        {rst_n, reg_wr, reg_rd, hdr_valid, reg_addr, reg_wdata} = '0;
        {frame_kind, is_tcp, is_udp, ip4_more_frag, ip4_frag_ofs} = '0;
        {ip4_hdr_len, cls_dscp, ip_dip, ip_sip, ip6_next_hdr, l4_head} = '0;
        {frame_payload, llc_ctrl, snap_pid, vlan_tagged} = '0;
        {frame_vid, port_vid, cnt, last_m} = '0;
        core_ce = 1'b1;
        en = 1'b1;
        for (int i = 0; i < 8; i++) {lo[i], hi[i], ty[i]} = {32'h0, 3'h7};
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(8'(8'h20 + 4 * i), 32'h7);
            rd(8'(4 * i), 32'h0);
        end
        rd(8'h40, 32'h1);
        rd(8'h80, 32'h0);
        rd(8'h41, 32'h0);
        rd(8'h44, 32'h0);
        idle();
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            logic [15:0] b;
            b = 16'(xs() % 32);
            wr(8'(4 * i), {16'(b + xs() % 32), b});
            wr(8'(8'h20 + 4 * i), (32'h57201043 >> (4 * i)) & 32'h7);
        end
        for (int i = 0; i < 8; i++) rd(8'(4 * i), {hi[i], lo[i]});
        idle();
        $display("test range_config done");
        repeat (300) begin
            hdr();
            if (xs() % 4 == 0) idle();
        end
        rd(8'h44, {cnt, 8'h00, last_m});
        idle();
        $display("test key_traffic done");
        wr(8'h40, 32'h0);
        hdr();
        hdr();
        rd(8'h40, 32'h0);
        wr(8'h40, 32'h1);
        hdr();
        idle();
        core_ce <= 1'b0;
        hdr();
        idle();
        core_ce <= 1'b1;
        rd(8'h44, {cnt, 8'h00, last_m});
        repeat (3) idle();
        chk("keys_left", 0, q7.size());
        chk("reads_left", 0, qr.size());
        $display("test refusal done");
        final_report();
    end
endmodule // tb_top
